// *** inc/enc_status_pkg.sv ***
// constants and carrier types of the encoder master status block
// assumes a byte-wide host register port decoded by the host interface
//
// Functional notes
// - late frame in auto acquisition skipped, skip flag driven low
// - any instruction register write lowers skip flag
// - skip flag is bit six of 0xf0
// - error pin low on any error; readback bit7
// - error pin wired-AND, external pulls seen
// - checksum result written to slave validity flag
// - checksum disabled: valid once data received
// - write to validity register clears its flags
// - validity bits 1,3,5,7 of 0xf1/0xf2
// - two banks of flags swap with data RAM
// - held swap sets bank switch failed bit
// - good register byte count in 0xf3[5:0]
// - count cleared on init or new control
// - idle bit after 14 frames with zero control
// - slave control bits sampled per channel, selected copy
// - control bit indications valid only without single bank
// - live data line levels at 0xf8 bits 0,2
// - pending swap done when hold released
// - frame due while held: skip swap, flag low
// - init restores frame skip flag, clears control finished
package enc_status_pkg;
   localparam logic [7:0] ADDR_ERROR_SUMMARY = 8'hf0;
   localparam logic [7:0] ADDR_VALID_LOW = 8'hf1;
   localparam logic [7:0] ADDR_VALID_HIGH = 8'hf2;
   localparam logic [7:0] ADDR_CTRL_COMM = 8'hf3;
   localparam logic [7:0] ADDR_INSTRUCTION = 8'hf4;
   localparam logic [7:0] ADDR_LINE_LEVEL = 8'hf8;
   localparam logic [7:0] ADDR_BANK_SWAP = 8'hfb;
   localparam int BIT_ERROR_PIN = 7;
   localparam int BIT_FRAME_SKIP = 6;
   localparam int BIT_IDLE_REACHED = 7;
   localparam int BIT_SEL_CTRL = 6;
   localparam int NUM_SLAVES = 8;
   localparam logic [3:0] IDLE_FRAME_COUNT = 4'he;
   localparam logic [5:0] GOOD_BYTES_RESET = 6'h00;
   localparam logic [7:0] VALID_RESET = 8'h00;

   typedef struct packed {
      logic frame_due;
      logic frame_busy;
      logic frame_end;
      logic master_ctrl_bit;
      logic [1:0] slave_ctrl_bit;
      logic [7:0] checksum_ok;
      logic [7:0] checksum_off;
      logic [7:0] slave_received;
   } frame_evt_t;

   typedef struct packed {
      logic init_start;
      logic ctrl_start;
      logic reg_error;
      logic reg_byte_ok;
   } ctrl_evt_t;
endpackage

// *** src/bank_flags.sv ***
// two banks of per-slave validity and slave control bits
// assumes swap and frame events are single-cycle pulses on the system clock
`timescale 1ns/1ps
`default_nettype none
module bank_flags (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_swap,
   input wire logic i_frame_end,
   input wire logic [7:0] i_valid_set,
   input wire logic [2:0] i_ctrl_bits,
   input wire logic i_clear_low,
   input wire logic i_clear_high,
   output logic [7:0] o_valid,
   output logic [2:0] o_ctrl_bits
);
   logic [7:0] valid_reg [2];
   logic [2:0] ctrl_reg [2];
   logic read_bank_reg;
   logic write_bank;
   assign write_bank = ~read_bank_reg;
   assign o_valid = valid_reg[read_bank_reg];
   assign o_ctrl_bits = ctrl_reg[read_bank_reg];

   // ------------------------------------------------------------
   // bank storage
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         read_bank_reg <= 1'b0;
         valid_reg[0] <= enc_status_pkg::VALID_RESET;
         valid_reg[1] <= enc_status_pkg::VALID_RESET;
         ctrl_reg[0] <= 3'h0;
         ctrl_reg[1] <= 3'h0;
      end else begin
         if (i_swap) begin
            read_bank_reg <= write_bank;
         end
         // host clear hits the visible bank; frame results land in
         // the hidden bank so a set is never lost to a clear
         if (i_clear_low) begin
            valid_reg[read_bank_reg][3:0] <= 4'h0;
         end
         if (i_clear_high) begin
            valid_reg[read_bank_reg][7:4] <= 4'h0;
         end
         if (i_frame_end) begin
            valid_reg[write_bank] <= i_valid_set;
            ctrl_reg[write_bank] <= i_ctrl_bits;
         end
      end
   end
endmodule // bank_flags
`default_nettype wire

// *** src/enc_status_regs.sv ***
// status and validity registers of the serial encoder master
// assumes frame and control events come from the sequencer on I_CLK_SYS
`timescale 1ns/1ps
`default_nettype none
module enc_status_regs (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   input wire logic [7:0] I_ADDR,
   input wire logic I_WR,
   input wire logic [7:0] I_WDATA,
   output logic [7:0] O_RDATA,
   input wire enc_status_pkg::frame_evt_t I_FRAME,
   input wire enc_status_pkg::ctrl_evt_t I_CTRL,
   input wire logic I_AUTO_ACQUISITION,
   input wire logic I_HOLD_BANK_SWITCH,
   input wire logic I_CHANNEL_SELECT,
   input wire logic I_SINGLE_BANK_MODE,
   input wire logic [1:0] I_OTHER_ERR_N,
   input wire logic I_SLAVE_DATA_LINE,
   input wire logic I_SECOND_SLAVE_DATA_INPUT,
   input wire logic I_ERROR_PIN_N,
   output logic O_ERROR_PIN_N,
   output logic O_ERROR_PIN_N_OE,
   output logic O_BANK_SWAP,
   output logic O_CONTROL_COMM_FINISHED_CLR
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         pin_meta_reg <= 3'h7;
         pin_sync_reg <= 3'h7;
      end else begin
         pin_meta_reg <= {I_ERROR_PIN_N, I_SECOND_SLAVE_DATA_INPUT,
                          I_SLAVE_DATA_LINE};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   logic error_pin_state;
   assign error_pin_state = pin_sync_reg[2];

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire instr_write = I_WR && (I_ADDR == enc_status_pkg::ADDR_INSTRUCTION);
   wire clear_low = I_WR && (I_ADDR == enc_status_pkg::ADDR_VALID_LOW);
   wire clear_high = I_WR && (I_ADDR == enc_status_pkg::ADDR_VALID_HIGH);

   // ------------------------------------------------------------
   // frame skip and bank swap
   // ------------------------------------------------------------
   logic frame_skip_flag_n_reg;
   logic swap_pending_reg;
   logic bank_switch_failed_reg;
   wire late_frame = I_AUTO_ACQUISITION && I_FRAME.frame_due
      && I_FRAME.frame_busy;
   wire held_frame = I_FRAME.frame_due && swap_pending_reg
      && I_HOLD_BANK_SWITCH;
   wire skip_event = late_frame || held_frame || instr_write;
   wire want_swap = I_FRAME.frame_end || swap_pending_reg;
   wire do_swap = want_swap && !I_HOLD_BANK_SWITCH;
   assign O_BANK_SWAP = do_swap;
   assign O_CONTROL_COMM_FINISHED_CLR = I_CTRL.init_start;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         frame_skip_flag_n_reg <= 1'b1;
         swap_pending_reg <= 1'b0;
         bank_switch_failed_reg <= 1'b0;
      end else begin
         // set of the error wins over the init restore
         if (skip_event) begin
            frame_skip_flag_n_reg <= 1'b0;
         end else if (I_CTRL.init_start) begin
            frame_skip_flag_n_reg <= 1'b1;
         end
         if (held_frame) begin
            swap_pending_reg <= 1'b0;
         end else begin
            swap_pending_reg <= want_swap && I_HOLD_BANK_SWITCH;
         end
         if (I_FRAME.frame_end && I_HOLD_BANK_SWITCH) begin
            bank_switch_failed_reg <= 1'b1;
         end else if (do_swap) begin
            bank_switch_failed_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // banked validity and control bits
   // ------------------------------------------------------------
   logic [7:0] valid_next;
   logic [7:0] valid_view;
   logic [2:0] ctrl_view;
   logic sel_ctrl;
   assign sel_ctrl = I_CHANNEL_SELECT ? I_FRAME.slave_ctrl_bit[1]
      : I_FRAME.slave_ctrl_bit[0];
   // disabled checksum counts as good once reception completed
   assign valid_next = (I_FRAME.checksum_ok & ~I_FRAME.checksum_off)
      | (I_FRAME.checksum_off & I_FRAME.slave_received);

   bank_flags u_bank (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .i_swap(do_swap),
      .i_frame_end(I_FRAME.frame_end),
      .i_valid_set(valid_next),
      .i_ctrl_bits({sel_ctrl, I_FRAME.slave_ctrl_bit}),
      .i_clear_low(clear_low),
      .i_clear_high(clear_high),
      .o_valid(valid_view),
      .o_ctrl_bits(ctrl_view)
   );

   // ------------------------------------------------------------
   // control communication counters
   // ------------------------------------------------------------
   logic [5:0] good_reg_byte_count_reg;
   logic [3:0] idle_frames_reg;
   logic control_idle_reached;
   assign control_idle_reached =
      (idle_frames_reg == enc_status_pkg::IDLE_FRAME_COUNT);

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         good_reg_byte_count_reg <= enc_status_pkg::GOOD_BYTES_RESET;
         idle_frames_reg <= 4'h0;
      end else begin
         if (I_CTRL.init_start || I_CTRL.ctrl_start) begin
            good_reg_byte_count_reg <= enc_status_pkg::GOOD_BYTES_RESET;
         end else if (I_CTRL.reg_byte_ok && !I_CTRL.reg_error
                      && good_reg_byte_count_reg != 6'h3f) begin
            good_reg_byte_count_reg <= good_reg_byte_count_reg + 6'h01;
         end
         if (I_FRAME.frame_end) begin
            if (I_FRAME.master_ctrl_bit) begin
               idle_frames_reg <= 4'h0;
            end else if (!control_idle_reached) begin
               idle_frames_reg <= idle_frames_reg + 4'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // error pin and read mux
   // ------------------------------------------------------------
   logic any_error;
   assign any_error = !frame_skip_flag_n_reg || !(&I_OTHER_ERR_N);
   assign O_ERROR_PIN_N = 1'b0;
   assign O_ERROR_PIN_N_OE = any_error;

   // single bank mode leaves control bits undefined; shown as read
   logic [7:0] rdata_next;
   always_comb begin
      rdata_next = 8'h00;
      unique case (I_ADDR)
         enc_status_pkg::ADDR_ERROR_SUMMARY:
            rdata_next = {error_pin_state, frame_skip_flag_n_reg,
                          6'h00};
         enc_status_pkg::ADDR_VALID_LOW:
            rdata_next = {valid_view[3], 1'b0, valid_view[2], 1'b0,
                          valid_view[1], 1'b0, valid_view[0], 1'b0};
         enc_status_pkg::ADDR_VALID_HIGH:
            rdata_next = {valid_view[7], 1'b0, valid_view[6], 1'b0,
                          valid_view[5], 1'b0, valid_view[4],
                          1'b0};
         enc_status_pkg::ADDR_CTRL_COMM:
            rdata_next = {control_idle_reached, ctrl_view[2],
                          good_reg_byte_count_reg};
         enc_status_pkg::ADDR_LINE_LEVEL:
            rdata_next = {4'h0, ctrl_view[1], pin_sync_reg[1],
                          ctrl_view[0], pin_sync_reg[0]};
         enc_status_pkg::ADDR_BANK_SWAP:
            rdata_next = {7'h00, bank_switch_failed_reg};
         default: rdata_next = 8'h00;
      endcase
   end
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RDATA <= 8'h00;
      end else begin
         O_RDATA <= rdata_next;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   skip_on_instr_a: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_RST_B) instr_write |=> !frame_skip_flag_n_reg)
      else $error("instruction write did not lower skip flag");
   skip_on_late_a: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_RST_B) late_frame |=> !frame_skip_flag_n_reg)
      else $error("late frame not flagged");
   pin_drive_a: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_RST_B) !frame_skip_flag_n_reg |-> O_ERROR_PIN_N_OE)
      else $error("error pin not pulled");
   fail_bit_a: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_RST_B) (I_FRAME.frame_end && I_HOLD_BANK_SWITCH)
      |=> bank_switch_failed_reg)
      else $error("held swap not reported");
   pending_swap_a: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_RST_B) (swap_pending_reg && !I_HOLD_BANK_SWITCH)
      |-> O_BANK_SWAP)
      else $error("pending swap not done");
   count_clear_a: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_RST_B) I_CTRL.ctrl_start
      |=> good_reg_byte_count_reg == 6'h00)
      else $error("byte count not cleared");
   idle_bit_a: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_RST_B) (I_FRAME.frame_end && I_FRAME.master_ctrl_bit)
      |=> !control_idle_reached)
      else $error("idle bit set after control frame");
   init_restore_a: assert property (@(posedge I_CLK_SYS)
      disable iff (!I_RST_B) (I_CTRL.init_start && !skip_event)
      |=> frame_skip_flag_n_reg)
      else $error("init did not restore skip flag");
endmodule // enc_status_regs
`default_nettype wire

// *** dv/slave_line_model.sv ***
// slave chain seen from the status block: data lines and error pull
// assumes the bench resolves the wired-AND error node from both pulls
`timescale 1ns/1ps
`default_nettype none
module slave_line_model (
   input wire logic i_run,
   input wire logic i_level1,
   input wire logic i_level2,
   input wire logic i_pull,
   output logic o_sl1,
   output var logic o_sl2,
   output logic o_pull
);
   assign o_sl1 = i_level1;
   // external part pulls the shared error node on its own fault
   assign o_pull = i_pull;
   // second line toggles on the 800 ns link clock only while running
   initial begin
      o_sl2 = 1'b1;
      // offset keeps every toggle off the sampling edge of the bench clock
      #25;
      forever begin
         #400;
         if (i_run) begin
            o_sl2 = ~o_sl2;
         end else begin
            o_sl2 = i_level2;
         end
      end
   end
endmodule // slave_line_model
`default_nettype wire

// *** dv/enc_status_regs_bench.sv ***
// self-checking bench of the encoder master status registers
// assumes one-cycle registered read data and pulse-type event inputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
 checks++; \
 if ((gt) !== (ex)) begin \
  num_errors++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); \
 end \
end
module enc_status_regs_bench;
   logic clk, rst_b, wr, auto_acq, hold, channel_select, run, lv1, lv2, pull, sl1, sl2;
   logic ext_pull, oe, pin_o, swap, fin_clr, err_pin_n;
   logic [7:0] addr, rdata, d;
   logic [1:0] other_n;
   enc_status_pkg::frame_evt_t fr;
   enc_status_pkg::ctrl_evt_t ct;
   int num_errors, checks, cyc;
   logic swap_seen, clr_seen;
   // ----------------------------------------
   // wired-AND error node
   // ----------------------------------------
   assign err_pin_n = (oe ? pin_o : 1'b1) & ~ext_pull;
   enc_status_regs u_enc_status_regs (.I_CLK_SYS(clk), .I_RST_B(rst_b),
      .I_ADDR(addr), .I_WR(wr), .I_WDATA(8'hff), .O_RDATA(rdata),
      .I_FRAME(fr), .I_CTRL(ct), .I_AUTO_ACQUISITION(auto_acq),
      .I_HOLD_BANK_SWITCH(hold), .I_CHANNEL_SELECT(channel_select),
      .I_SINGLE_BANK_MODE(1'b0), .I_OTHER_ERR_N(other_n),
      .I_SLAVE_DATA_LINE(sl1), .I_SECOND_SLAVE_DATA_INPUT(sl2),
      .I_ERROR_PIN_N(err_pin_n), .O_ERROR_PIN_N(pin_o),
      .O_ERROR_PIN_N_OE(oe), .O_BANK_SWAP(swap),
      .O_CONTROL_COMM_FINISHED_CLR(fin_clr));
   slave_line_model u_slave_line_model (.i_run(run), .i_level1(lv1),
      .i_level2(lv2), .i_pull(pull), .o_sl1(sl1), .o_sl2(sl2),
      .o_pull(ext_pull));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // cut a hang short well past the few hundred cycles expected
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         print_verdict();
      end
   end
   // ----------------------------------------
   // bus and event tasks
   // ----------------------------------------
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk) addr = a;
      repeat (2) @(posedge clk);
      @(negedge clk) v = rdata;
   endtask
   task automatic wr_reg(input logic [7:0] a);
      @(negedge clk) begin addr = a; wr = 1'b1; end
      @(negedge clk) wr = 1'b0;
   endtask
   task automatic frame_end(input logic [7:0] ok, off, rx, input logic mcb);
      @(negedge clk) begin
         fr.frame_end = 1'b1; fr.checksum_ok = ok; fr.checksum_off = off;
         fr.slave_received = rx; fr.master_ctrl_bit = mcb;
      end
      #1 swap_seen = swap;
      @(negedge clk) fr.frame_end = 1'b0;
   endtask
   task automatic pulse_ctrl(input logic [3:0] p);
      @(negedge clk) ct = p;
      #1 clr_seen = fin_clr;
      @(negedge clk) ct = 4'h0;
   endtask
   task automatic init_seq();
      pulse_ctrl(4'h8);
      `CHK("fin_clr", 1'b1, clr_seen)
      rd(enc_status_pkg::ADDR_ERROR_SUMMARY, d);
      `CHK("skip_init", 1'b1, d[6])
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(enc_status_pkg::ADDR_ERROR_SUMMARY, d);
      `CHK("f0_7_6", 2'b11, d[7:6])
      rd(enc_status_pkg::ADDR_VALID_LOW, d);
      `CHK("f1", 8'h00, d)
      rd(enc_status_pkg::ADDR_CTRL_COMM, d);
      `CHK("f3_cnt", 6'h00, d[5:0])
      rd(enc_status_pkg::ADDR_BANK_SWAP, d);
      `CHK("fb0", 1'b0, d[0])
      rd(8'h10, d);
      `CHK("unmapped", 8'h00, d)
      $display("test reset done");
   endtask
   task automatic t_valid();
      channel_select = 1'b1;
      fr.slave_ctrl_bit = 2'b10;
      frame_end(8'h05, 8'h80, 8'h80, 1'b1);
      `CHK("swap", 1'b1, swap_seen)
      rd(enc_status_pkg::ADDR_VALID_LOW, d);
      `CHK("f1", 8'h22, d)
      rd(enc_status_pkg::ADDR_VALID_HIGH, d);
      `CHK("f2", 8'h80, d)
      rd(enc_status_pkg::ADDR_LINE_LEVEL, d);
      `CHK("cds", 2'b10, {d[3], d[1]})
      rd(enc_status_pkg::ADDR_CTRL_COMM, d);
      `CHK("selected_slave_ctrl_bit", 1'b1, d[6])
      wr_reg(enc_status_pkg::ADDR_VALID_LOW);
      rd(enc_status_pkg::ADDR_VALID_LOW, d);
      `CHK("f1_clr", 8'h00, d)
      rd(enc_status_pkg::ADDR_VALID_HIGH, d);
      `CHK("f2_kept", 8'h80, d)
      wr_reg(enc_status_pkg::ADDR_VALID_HIGH);
      rd(enc_status_pkg::ADDR_VALID_HIGH, d);
      `CHK("f2_clr", 8'h00, d)
      $display("test valid done");
   endtask
   task automatic t_hold();
      hold = 1'b1;
      frame_end(8'h02, 8'h00, 8'h00, 1'b1);
      `CHK("no_swap", 1'b0, swap_seen)
      rd(enc_status_pkg::ADDR_BANK_SWAP, d);
      `CHK("fb0", 1'b1, d[0])
      rd(enc_status_pkg::ADDR_VALID_LOW, d);
      `CHK("f1_held", 8'h00, d)
      @(negedge clk) hold = 1'b0;
      rd(enc_status_pkg::ADDR_VALID_LOW, d);
      `CHK("f1_late", 8'h08, d)
      rd(enc_status_pkg::ADDR_BANK_SWAP, d);
      `CHK("fb0_ok", 1'b0, d[0])
      hold = 1'b1;
      frame_end(8'h00, 8'h00, 8'h00, 1'b1);
      @(negedge clk) fr.frame_due = 1'b1;
      @(negedge clk) fr.frame_due = 1'b0;
      hold = 1'b0;
      rd(enc_status_pkg::ADDR_ERROR_SUMMARY, d);
      `CHK("skip_held", 1'b0, d[6])
      rd(enc_status_pkg::ADDR_VALID_LOW, d);
      `CHK("f1_noswap", 8'h08, d)
      init_seq();
      $display("test hold done");
   endtask
   task automatic t_skip();
      auto_acq = 1'b1;
      @(negedge clk) begin fr.frame_busy = 1'b1; fr.frame_due = 1'b1; end
      @(negedge clk) begin fr.frame_busy = 1'b0; fr.frame_due = 1'b0; end
      repeat (3) @(negedge clk);
      rd(enc_status_pkg::ADDR_ERROR_SUMMARY, d);
      `CHK("skip_late", 2'b00, d[7:6])
      auto_acq = 1'b0;
      init_seq();
      wr_reg(enc_status_pkg::ADDR_INSTRUCTION);
      rd(enc_status_pkg::ADDR_ERROR_SUMMARY, d);
      `CHK("skip_wr", 1'b0, d[6])
      init_seq();
      $display("test skip done");
   endtask
   task automatic t_pins();
      pull = 1'b1;
      lv1 = 1'b1;
      lv2 = 1'b0;
      repeat (6) @(negedge clk);
      rd(enc_status_pkg::ADDR_ERROR_SUMMARY, d);
      `CHK("ext_pull", 2'b01, d[7:6])
      rd(enc_status_pkg::ADDR_LINE_LEVEL, d);
      `CHK("lines", 2'b01, {d[2], d[0]})
      pull = 1'b0;
      other_n = 2'b01;
      repeat (4) @(negedge clk);
      rd(enc_status_pkg::ADDR_ERROR_SUMMARY, d);
      `CHK("other_err", 1'b0, d[7])
      other_n = 2'b11;
      repeat (4) @(negedge clk);
      rd(enc_status_pkg::ADDR_ERROR_SUMMARY, d);
      `CHK("no_err", 1'b1, d[7])
      // running link line flips once per 400 ns, so two looks differ
      run = 1'b1;
      @(negedge clk) addr = enc_status_pkg::ADDR_LINE_LEVEL;
      repeat (4) @(negedge clk);
      d = rdata;
      repeat (4) @(negedge clk);
      `CHK("sl2_toggle", ~d[2], rdata[2])
      run = 1'b0;
      $display("test pins done");
   endtask
   task automatic t_ctrl();
      for (int i = 1; i <= 14; i++) begin
         frame_end(8'h00, 8'h00, 8'h00, 1'b0);
         rd(enc_status_pkg::ADDR_CTRL_COMM, d);
         `CHK("idle", (i == 14), d[7])
      end
      // control traffic starts only once the idle count is reached
      pulse_ctrl(4'h4);
      repeat (3) pulse_ctrl(4'h1);
      pulse_ctrl(4'h2);
      rd(enc_status_pkg::ADDR_CTRL_COMM, d);
      `CHK("good_bytes", 6'h03, d[5:0])
      pulse_ctrl(4'h4);
      rd(enc_status_pkg::ADDR_CTRL_COMM, d);
      `CHK("bytes_clr", 6'h00, d[5:0])
      frame_end(8'h00, 8'h00, 8'h00, 1'b1);
      rd(enc_status_pkg::ADDR_CTRL_COMM, d);
      `CHK("idle_off", 1'b0, d[7])
      $display("test ctrl done");
   endtask
   task automatic print_verdict();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      {rst_b, wr, auto_acq, hold, channel_select, run, lv1, lv2, pull} = 9'h006;
      addr = 8'h00;
      other_n = 2'b11;
      fr = '0;
      ct = '0;
      repeat (2) @(posedge clk);
      @(negedge clk) rst_b = 1'b1;
      t_reset();
      t_valid();
      t_hold();
      t_skip();
      t_pins();
      t_ctrl();
      print_verdict();
   end
endmodule // enc_status_regs_bench
`default_nettype wire
